//--- hdl/shared_ram_strobe_logic.sv
// read and per-lane write strobes for the shared processor/host ram
`timescale 1ns/10ps
`include "shared_ram_params.svh"

module shared_ram_strobe_logic #(
    parameter int LANES      = `RAM_LANES,
    parameter int CHIP_DEPTH = `RAM_CHIP_DEPTH
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // processor memory port
    input  wire logic                          procTransferStrobeN,
    input  wire logic                          procReadWrite,
    input  wire logic                          procBusAcknowledgeN,
    input  wire logic                          procBusGrantN,
    // arbiter state
    input  wire logic                          hostAccessState,
    input  wire logic                          ramHide,
    // host bus
    input  wire logic                          hostAddrLatchEn,
    input  wire logic                          hostAen,
    input  wire logic [`HOST_WIN_LA_WIDTH-1:0] hostUpperAddr,
    input  wire logic                          hostAddr0,
    input  wire logic                          hostAddr1,
    input  wire logic                          hostByteHighN,
    input  wire logic                          hostMemReadN,
    input  wire logic                          hostMemWriteN,
    // ram strobes
    output logic                               readStrobeN,
    output logic                               lane0WriteStrobeN,
    output logic                               lane1WriteStrobeN,
    output logic                               lane2WriteStrobeN,
    output logic                               lane3WriteStrobeN,
    // address buffer enable
    output logic                               hostPathEnableN
);

    localparam int SW = 13 + `HOST_WIN_LA_WIDTH;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    // every strobe lags its command pins by two clocks, the latched address pins by three; the price of a safe crossing
    logic [SW-1:0] pinsAsync;
    logic [SW-1:0] pinsSync;

    assign pinsAsync = {procTransferStrobeN, procReadWrite, procBusAcknowledgeN, procBusGrantN,
                        hostAccessState, ramHide, hostAddrLatchEn, hostAen, hostAddr0, hostAddr1,
                        hostByteHighN, hostMemReadN, hostMemWriteN, hostUpperAddr};

    sync_2ff #(
        .WIDTH   (SW)
    ) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (pinsAsync),
        .syncOut (pinsSync)
    );

    logic                          tsN;
    logic                          rw;
    logic                          baN;
    logic                          bgN;
    logic                          accState;
    logic                          hide;
    logic                          ale;
    logic                          aen;
    logic                          sa0;
    logic                          sa1;
    logic                          sbheN;
    logic                          memRdN;
    logic                          memWrN;
    logic [`HOST_WIN_LA_WIDTH-1:0] la;

    assign {tsN, rw, baN, bgN, accState, hide, ale, aen, sa0, sa1, sbheN, memRdN, memWrN, la} = pinsSync;

    // ----------------------------------------------------------------
    // host address latch
    // ----------------------------------------------------------------
    // transparent while latch enable is high, holds after it falls
    logic hostMemDecode;
    logic memHit_reg;
    logic memHit_next;
    logic latchedDmaFlag_reg;
    logic latchedDmaFlag_next;

    assign hostMemDecode = (la == `HOST_WIN_LA_MATCH);

    always_comb begin
        memHit_next         = memHit_reg;
        latchedDmaFlag_next = latchedDmaFlag_reg;
        if (ale) begin
            memHit_next         = hostMemDecode;
            latchedDmaFlag_next = aen;
        end
    end

    // dma flag resets set so no host cycle reaches the array before a latch
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            memHit_reg         <= `RST_MEM_HIT;
            latchedDmaFlag_reg <= `RST_DMA_FLAG;
        end else begin
            memHit_reg         <= memHit_next;
            latchedDmaFlag_reg <= latchedDmaFlag_next;
        end
    end

    // ----------------------------------------------------------------
    // ownership
    // ----------------------------------------------------------------
    logic                       hostPathEn;
    shared_ram_pkg::access_kind_t accessKind;

    assign hostPathEn = !baN && !bgN ? 1'b0 : (baN && bgN && accState);

    always_comb begin
        if (!hostPathEn && !baN) begin
            accessKind = shared_ram_pkg::ACC_PROC;
        end else if (hostPathEn && baN) begin
            accessKind = shared_ram_pkg::ACC_HOST;
        end else begin
            accessKind = shared_ram_pkg::ACC_NONE;
        end
    end

    // ----------------------------------------------------------------
    // strobe generation
    // ----------------------------------------------------------------
    // host gate shared by reads and writes
    logic             hostOk;
    logic             readAct;
    logic [LANES-1:0] writeAct;

    assign hostOk = memHit_reg && !latchedDmaFlag_reg && !hide;

    always_comb begin
        readAct  = 1'b0;
        writeAct = '0;
        unique case (accessKind)
            shared_ram_pkg::ACC_PROC: begin
                readAct  = !tsN && rw;
                writeAct = {LANES{!tsN && !rw}};
            end
            shared_ram_pkg::ACC_HOST: begin
                readAct = hostOk && !memRdN;
                if (hostOk && !memWrN) begin
                    writeAct[0] = !sa1 && !sa0;
                    writeAct[1] = !sa1 && !sbheN;
                    writeAct[2] = sa1 && !sa0;
                    writeAct[3] = sa1 && !sbheN;
                end
            end
            shared_ram_pkg::ACC_NONE: begin
                readAct  = 1'b0;
                writeAct = '0;
            end
        endcase
    end

    // combinational so a strobe falls with its bus condition
    assign readStrobeN       = !readAct;
    assign lane0WriteStrobeN = !writeAct[0];
    assign lane1WriteStrobeN = !writeAct[1];
    assign lane2WriteStrobeN = !writeAct[2];
    assign lane3WriteStrobeN = !writeAct[3];
    assign hostPathEnableN   = !hostPathEn;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_proc_read: assert property (
        (!hostPathEn && !baN && !tsN && rw) |-> !readStrobeN && lane0WriteStrobeN)
        else $error("processor read strobe wrong");

    chk_proc_write_all: assert property (
        (!hostPathEn && !baN && !tsN && !rw) |->
            !lane0WriteStrobeN && !lane1WriteStrobeN && !lane2WriteStrobeN && !lane3WriteStrobeN)
        else $error("processor write not on all lanes");

    chk_host_read: assert property (
        (hostPathEn && baN) |-> (!readStrobeN == (memHit_reg && !latchedDmaFlag_reg && !hide && !memRdN)))
        else $error("host read strobe mismatch");

    chk_host_lane_sel: assert property (
        (hostPathEn && baN && hostOk && !memWrN) |->
            (!lane1WriteStrobeN == (!sa1 && !sbheN)) && (!lane2WriteStrobeN == (sa1 && !sa0)))
        else $error("host lane select wrong");

    chk_hide_blocks: assert property (
        (hostPathEn && hide) |-> readStrobeN && lane0WriteStrobeN && lane3WriteStrobeN)
        else $error("hidden ram was strobed");

    chk_dma_blocks: assert property (
        (hostPathEn && latchedDmaFlag_reg) |-> readStrobeN && lane2WriteStrobeN)
        else $error("dma cycle reached the array");

    chk_latch_hold: assert property (
        (!ale ##1 !ale) |-> $stable(memHit_reg) && $stable(latchedDmaFlag_reg))
        else $error("latched flags moved while latch closed");

    chk_latch_capture: assert property (
        ale |=> (memHit_reg == $past(hostMemDecode)) && (latchedDmaFlag_reg == $past(aen)))
        else $error("latched flags not captured");

    chk_path_enable: assert property (
        !hostPathEnableN |-> baN && bgN && accState)
        else $error("host path enabled without release");

    chk_no_owner: assert property (
        (hostPathEn == !baN) |-> readStrobeN && lane0WriteStrobeN && lane1WriteStrobeN)
        else $error("strobe without an owner");

endmodule // shared_ram_strobe_logic

//--- hdl/shared_ram_params.svh
// constants for the shared ram strobe logic
`ifndef SHARED_RAM_PARAMS_SVH
`define SHARED_RAM_PARAMS_SVH

// ----------------------------------------------------------------
// host memory window decode, upper address lines 23..17
// ----------------------------------------------------------------
`define HOST_WIN_LA_WIDTH   7
`define HOST_WIN_LA_MATCH   7'h04
`define HOST_WIN_BASE       24'h080000
`define HOST_WIN_LAST       24'h09FFFF

// ----------------------------------------------------------------
// array organisation
// ----------------------------------------------------------------
`define RAM_LANES           4
`define RAM_CHIP_DEPTH      32768
`define RAM_HOST_BYTES      131072

// ----------------------------------------------------------------
// input synchroniser
// ----------------------------------------------------------------
`define SYNC_STAGES         2
`define SYNC_RESET_VAL      1'h1

// ----------------------------------------------------------------
// reset values of the latched host flags
// ----------------------------------------------------------------
`define RST_MEM_HIT         1'h0
`define RST_DMA_FLAG        1'h1

`endif

//--- hdl/shared_ram_pkg.sv
// types for the shared ram strobe logic
package shared_ram_pkg;

    // who owns the array this cycle; gray along none -> proc -> host
    typedef enum logic [1:0] {
        ACC_NONE = 2'h0,
        ACC_PROC = 2'h1,
        ACC_HOST = 2'h3
    } access_kind_t;

endpackage

//--- hdl/sync_2ff.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`include "shared_ram_params.svh"

module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // async side
    input  wire logic [WIDTH-1:0] asyncIn,
    // synchronous side
    output logic      [WIDTH-1:0] syncOut
);

    // ----------------------------------------------------------------
    // stages
    // ----------------------------------------------------------------
    // stage one feeds only stage two
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_next;

    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage1_reg <= {WIDTH{`SYNC_RESET_VAL}};
            stage2_reg <= {WIDTH{`SYNC_RESET_VAL}};
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign syncOut = stage2_reg;

endmodule // sync_2ff

//--- tb/shared_ram_bus_model.sv
// behavioural host bus and processor port facing the strobe logic
`timescale 1ns/10ps
`include "shared_ram_params.svh"

module shared_ram_bus_model (
    // clock
    input  wire logic                          ref_clk,
    // processor port
    output logic                               procTransferStrobeN,
    output logic                               procReadWrite,
    // host bus
    output logic                               hostAddrLatchEn,
    output logic                               hostAen,
    output logic [`HOST_WIN_LA_WIDTH-1:0]      hostUpperAddr,
    output logic                               hostAddr0,
    output logic                               hostAddr1,
    output logic                               hostByteHighN,
    output logic                               hostMemReadN,
    output logic                               hostMemWriteN
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    initial begin
        procTransferStrobeN = 1'h1;
        procReadWrite       = 1'h1;
        hostAddrLatchEn     = 1'h0;
        hostAen             = 1'h1;
        hostUpperAddr       = 7'h00;
        {hostAddr1, hostAddr0, hostByteHighN} = 3'h1;
        {hostMemReadN, hostMemWriteN}         = 2'h3;
    end

    // ----------------------------------------------------------------
    // transfers
    // ----------------------------------------------------------------
    task automatic procDrive(input logic ts, input logic rw);
        @(posedge ref_clk);
        procTransferStrobeN <= ts;
        procReadWrite       <= rw;
    endtask

    // upper lines are not held after the latch closes: show their inverse
    task automatic hostAddress(input logic [`HOST_WIN_LA_WIDTH-1:0] upper, input logic aen);
        @(posedge ref_clk);
        hostAddrLatchEn <= 1'h1;
        hostUpperAddr   <= upper;
        hostAen         <= aen;
        repeat (2) @(posedge ref_clk);
        hostAddrLatchEn <= 1'h0;
        @(posedge ref_clk);
        hostUpperAddr   <= ~upper;
        hostAen         <= ~aen;
    endtask

    task automatic hostCmd(input logic rdN, input logic wrN, input logic a1, input logic a0, input logic bheN);
        @(posedge ref_clk);
        hostMemReadN  <= rdN;
        hostMemWriteN <= wrN;
        hostAddr1     <= a1;
        hostAddr0     <= a0;
        hostByteHighN <= bheN;
    endtask
endmodule // shared_ram_bus_model

//--- tb/test_shared_ram_strobe_logic.sv
// self-checking bench for the shared ram strobe logic
`timescale 1ns/10ps
`include "shared_ram_params.svh"

module test_shared_ram_strobe_logic;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                          ref_clk = 1'h0;
    logic                          sys_rst = 1'h1;
    logic                          procTransferStrobeN, procReadWrite;
    logic                          procBusAcknowledgeN = 1'h1;
    logic                          procBusGrantN = 1'h1;
    logic                          hostAccessState = 1'h0;
    logic                          ramHide = 1'h1;
    logic                          hostAddrLatchEn, hostAen, hostAddr0, hostAddr1;
    logic                          hostByteHighN, hostMemReadN, hostMemWriteN;
    logic [`HOST_WIN_LA_WIDTH-1:0] hostUpperAddr;
    logic                          readStrobeN, hostPathEnableN;
    logic                          lane0WriteStrobeN, lane1WriteStrobeN, lane2WriteStrobeN, lane3WriteStrobeN;
    int                            err_count = 0;
    int                            check_count = 0;

    always #2 ref_clk = ~ref_clk;

    shared_ram_strobe_logic dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .procTransferStrobeN(procTransferStrobeN), .procReadWrite(procReadWrite),
        .procBusAcknowledgeN(procBusAcknowledgeN), .procBusGrantN(procBusGrantN),
        .hostAccessState(hostAccessState), .ramHide(ramHide), .hostAddrLatchEn(hostAddrLatchEn),
        .hostAen(hostAen), .hostUpperAddr(hostUpperAddr), .hostAddr0(hostAddr0), .hostAddr1(hostAddr1),
        .hostByteHighN(hostByteHighN), .hostMemReadN(hostMemReadN), .hostMemWriteN(hostMemWriteN),
        .readStrobeN(readStrobeN), .lane0WriteStrobeN(lane0WriteStrobeN),
        .lane1WriteStrobeN(lane1WriteStrobeN), .lane2WriteStrobeN(lane2WriteStrobeN),
        .lane3WriteStrobeN(lane3WriteStrobeN), .hostPathEnableN(hostPathEnableN));

    shared_ram_bus_model busModel (.ref_clk(ref_clk), .procTransferStrobeN(procTransferStrobeN),
        .procReadWrite(procReadWrite), .hostAddrLatchEn(hostAddrLatchEn), .hostAen(hostAen),
        .hostUpperAddr(hostUpperAddr), .hostAddr0(hostAddr0), .hostAddr1(hostAddr1),
        .hostByteHighN(hostByteHighN), .hostMemReadN(hostMemReadN), .hostMemWriteN(hostMemWriteN));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // result packed as path enable, read, lanes 3..0
    task automatic chk(input string what, input logic [5:0] expv);
        logic [5:0] seen;
        seen = {hostPathEnableN, readStrobeN, lane3WriteStrobeN, lane2WriteStrobeN,
                lane1WriteStrobeN, lane0WriteStrobeN};
        check_count++;
        if (seen !== expv) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // two-stage input sync plus latch: four edges is past every path
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic setOwner(input logic baN, input logic bgN, input logic acc, input logic hide);
        @(posedge ref_clk);
        procBusAcknowledgeN <= baN;
        procBusGrantN       <= bgN;
        hostAccessState     <= acc;
        ramHide             <= hide;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // pending host write must not leak into processor cycles
    task automatic proc_access_test;
        setOwner(1'h0, 1'h0, 1'h0, 1'h0);
        busModel.hostAddress(7'h04, 1'h0);
        busModel.hostCmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        busModel.procDrive(1'h0, 1'h1);
        settle;
        chk("proc read", 6'h2F);
        busModel.procDrive(1'h0, 1'h0);
        settle;
        chk("proc write", 6'h30);
        busModel.procDrive(1'h1, 1'h0);
        settle;
        chk("proc idle", 6'h3F);
        busModel.hostCmd(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
    endtask

    task automatic path_enable_test;
        for (int i = 0; i < 8; i++) begin
            setOwner(i[2], i[1], i[0], 1'h1);
            settle;
            chk("path enable", {~(i[2] & i[1] & i[0]), 5'h1F});
        end
    endtask

    // processor strobe held low throughout: host path must ignore it
    task automatic host_lane_test;
        logic       a1, a0, bheN;
        logic [5:0] expLanes;
        setOwner(1'h1, 1'h1, 1'h1, 1'h0);
        busModel.procDrive(1'h0, 1'h0);
        busModel.hostAddress(7'h04, 1'h0);
        for (int i = 0; i < 8; i++) begin
            {a1, a0, bheN} = i[2:0];
            busModel.hostCmd(1'h1, 1'h0, a1, a0, bheN);
            settle;
            expLanes = {2'h1, ~(a1 & ~bheN), ~(a1 & ~a0), ~(~a1 & ~bheN), ~(~a1 & ~a0)};
            chk("host write lanes", expLanes);
        end
        busModel.hostCmd(1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        settle;
        chk("host read", 6'h0F);
        busModel.hostCmd(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        busModel.procDrive(1'h1, 1'h1);
    endtask

    // hide, dma cycle, window just above, window just below
    task automatic host_block_test;
        for (int j = 0; j < 4; j++) begin
            setOwner(1'h1, 1'h1, 1'h1, j == 0);
            busModel.hostAddress((j == 2) ? 7'h05 : ((j == 3) ? 7'h03 : 7'h04), j == 1);
            busModel.hostCmd(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
            settle;
            chk("blocked write", 6'h1F);
            busModel.hostCmd(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
            settle;
            chk("blocked read", 6'h1F);
            busModel.hostCmd(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
        end
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        proc_access_test;
        path_enable_test;
        host_lane_test;
        host_block_test;
        complete_run;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        complete_run;
    end
endmodule // test_shared_ram_strobe_logic
